// ==== uohc_top.sv ====
// hardware configuration bank, upper bits: sleep pin disable, transceiver
// low power in suspend, port-2 pull-down connect
// assumes an ahb-lite master on SYS_CLK_IN and pad logic on the pin ports
//
// Functional notes
// - Setting bit 15 turns off the sleep pin function of both controllers.
// - While that function is off both sleep pins are driven high steadily.
// - While that function is off a low on either sleep pin wakes nobody.
// - Setting bit 14 puts the transceiver in low power while it is suspended.
// - Bit 13 connects (1) or disconnects (0) both port-2 line pull-downs.
// - Port 2 is always a host port, so its pull-down control is unconditional.
`timescale 1ns/1ps
module uohc_top
    import uohc_pkg::*;
(
    input wire logic SYS_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic HREADY_IN,
    input wire logic [31:0] HWDATA_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    input wire logic HC_SUSPEND_IN,
    input wire logic DC_SUSPEND_IN,
    input wire logic TRX_SUSPEND_IN,
    input wire logic HC_SLEEP_PIN_IN,
    output logic HC_SLEEP_PIN_OUT,
    output logic HC_SLEEP_PIN_OE_OUT,
    input wire logic DC_SLEEP_PIN_IN,
    output logic DC_SLEEP_PIN_OUT,
    output logic DC_SLEEP_PIN_OE_OUT,
    output logic HC_WAKE_OUT,
    output logic DC_WAKE_OUT,
    output logic TRX_LOW_POWER_OUT,
    output logic PORT2_MINUS_PULLDOWN_OUT,
    output logic PORT2_PLUS_PULLDOWN_OUT
);
    localparam int CW = `UOHC_CNT_W;
    localparam logic [2:0] CFG_RST = `UOHC_CFG_RESET;

    uohc_reg_if bus ();

    logic sleep_pin_function_off;
    logic transceiver_low_power;
    logic port2_pulldown_connect;
    logic next_sleep_pin_function_off;
    logic next_transceiver_low_power;
    logic next_port2_pulldown_connect;

    logic [CW-1:0] hc_wake_cnt;
    logic [CW-1:0] dc_wake_cnt;
    logic [CW-1:0] ignored_cnt;
    logic [CW-1:0] next_hc_wake_cnt;
    logic [CW-1:0] next_dc_wake_cnt;
    logic [CW-1:0] next_ignored_cnt;

    logic hc_level;
    logic dc_level;
    logic hc_wake;
    logic dc_wake;
    logic hc_ignored;
    logic dc_ignored;
    logic wr_cfg;
    logic wr_wake;
    logic [1:0] ignored_pair;
    uohc_word_t status_word;
    uohc_word_t next_cfg_word;
    uohc_word_t next_wake_word;

    // HSIZE_IN is not decoded: only whole-word transfers are supported
    // ======================================================================
    // bus slave
    uohc_ahb_slave u_slave (
        .clk_in(SYS_CLK_IN),
        .rst_n_in(RST_N_IN),
        .hsel_in(HSEL_IN),
        .haddr_in(HADDR_IN),
        .htrans_in(HTRANS_IN),
        .hwrite_in(HWRITE_IN),
        .hready_in(HREADY_IN),
        .hwdata_in(HWDATA_IN),
        .hrdata_out(HRDATA_OUT),
        .hreadyout_out(HREADYOUT_OUT),
        .hresp_out(HRESP_OUT),
        .bus(bus.slave)
    );

    // ======================================================================
    // write decode
    assign wr_cfg = bus.wr_en && (uohc_decode(bus.wr_addr) == UOHC_REG_CFG);
    assign wr_wake = bus.wr_en && (uohc_decode(bus.wr_addr) == UOHC_REG_WAKE);

    // ======================================================================
    // hardware_configuration
    always_comb begin
        next_sleep_pin_function_off = sleep_pin_function_off;
        next_transceiver_low_power = transceiver_low_power;
        next_port2_pulldown_connect = port2_pulldown_connect;
        if (wr_cfg) begin
            next_sleep_pin_function_off = bus.wr_data[`UOHC_SLEEP_OFF_BIT];
            next_transceiver_low_power = bus.wr_data[`UOHC_LOW_POWER_BIT];
            next_port2_pulldown_connect = bus.wr_data[`UOHC_PULLDOWN_BIT];
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            sleep_pin_function_off <= CFG_RST[2];
            transceiver_low_power <= CFG_RST[1];
            port2_pulldown_connect <= CFG_RST[0];
        end else begin
            sleep_pin_function_off <= next_sleep_pin_function_off;
            transceiver_low_power <= next_transceiver_low_power;
            port2_pulldown_connect <= next_port2_pulldown_connect;
        end
    end

    // ======================================================================
    // sleep pins of both controllers share the one disable bit
    uohc_sleep_pin u_hc_pin (
        .clk_in(SYS_CLK_IN),
        .rst_n_in(RST_N_IN),
        .func_off_in(sleep_pin_function_off),
        .suspend_in(HC_SUSPEND_IN),
        .pin_in(HC_SLEEP_PIN_IN),
        .pin_out(HC_SLEEP_PIN_OUT),
        .pin_oe_out(HC_SLEEP_PIN_OE_OUT),
        .level_out(hc_level),
        .wake_out(hc_wake),
        .ignored_out(hc_ignored)
    );

    uohc_sleep_pin u_dc_pin (
        .clk_in(SYS_CLK_IN),
        .rst_n_in(RST_N_IN),
        .func_off_in(sleep_pin_function_off),
        .suspend_in(DC_SUSPEND_IN),
        .pin_in(DC_SLEEP_PIN_IN),
        .pin_out(DC_SLEEP_PIN_OUT),
        .pin_oe_out(DC_SLEEP_PIN_OE_OUT),
        .level_out(dc_level),
        .wake_out(dc_wake),
        .ignored_out(dc_ignored)
    );

    // pin module drives high with enable set whenever the function is off
    // and gates its wake pulse with the same bit
    assign HC_WAKE_OUT = hc_wake;
    assign DC_WAKE_OUT = dc_wake;

    // ======================================================================
    // transceiver and port-2 pads
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            TRX_LOW_POWER_OUT <= 1'b0;
        end else begin
            TRX_LOW_POWER_OUT <= transceiver_low_power & TRX_SUSPEND_IN;
        end
    end

    // no role input gates this: port 2 never changes role
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            PORT2_MINUS_PULLDOWN_OUT <= 1'b0;
            PORT2_PLUS_PULLDOWN_OUT <= 1'b0;
        end else begin
            PORT2_MINUS_PULLDOWN_OUT <= port2_pulldown_connect;
            PORT2_PLUS_PULLDOWN_OUT <= port2_pulldown_connect;
        end
    end

    // ======================================================================
    // wake event counters; a write to the wake register clears them, a same-cycle event
    // still counts so nothing is lost
    function automatic logic [CW-1:0] sat_step(input logic [CW-1:0] cnt,
        input logic clr, input logic [1:0] inc);
        logic [CW:0] sum;
        logic [CW-1:0] base;
        base = clr ? `UOHC_CNT_RESET : cnt;
        sum = {1'b0, base} + {{(CW-1){1'b0}}, inc};
        // saturate rather than wrap so a busy pin never reads as quiet
        return sum[CW] ? {CW{1'b1}} : sum[CW-1:0];
    endfunction

    assign ignored_pair = {1'b0, hc_ignored} + {1'b0, dc_ignored};

    always_comb begin
        next_hc_wake_cnt = sat_step(hc_wake_cnt, wr_wake, {1'b0, hc_wake});
        next_dc_wake_cnt = sat_step(dc_wake_cnt, wr_wake, {1'b0, dc_wake});
        next_ignored_cnt = sat_step(ignored_cnt, wr_wake, ignored_pair);
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            hc_wake_cnt <= `UOHC_CNT_RESET;
            dc_wake_cnt <= `UOHC_CNT_RESET;
            ignored_cnt <= `UOHC_CNT_RESET;
        end else begin
            hc_wake_cnt <= next_hc_wake_cnt;
            dc_wake_cnt <= next_dc_wake_cnt;
            ignored_cnt <= next_ignored_cnt;
        end
    end

    // ======================================================================
    // read side; configuration and wake words built from next values so a
    // back-to-back read after a write returns the new contents
    always_comb begin
        next_cfg_word = 32'h00000000;
        next_cfg_word[`UOHC_SLEEP_OFF_BIT] = next_sleep_pin_function_off;
        next_cfg_word[`UOHC_LOW_POWER_BIT] = next_transceiver_low_power;
        next_cfg_word[`UOHC_PULLDOWN_BIT] = next_port2_pulldown_connect;
    end

    always_comb begin
        status_word = 32'h00000000;
        status_word[`UOHC_ST_HC_PIN_BIT] = hc_level;
        status_word[`UOHC_ST_DC_PIN_BIT] = dc_level;
        status_word[`UOHC_ST_HC_SUSP_BIT] = HC_SUSPEND_IN;
        status_word[`UOHC_ST_DC_SUSP_BIT] = DC_SUSPEND_IN;
        status_word[`UOHC_ST_LOW_PWR_BIT] = TRX_LOW_POWER_OUT;
        status_word[`UOHC_ST_PULLDOWN_BIT] = PORT2_PLUS_PULLDOWN_OUT;
        status_word[`UOHC_ST_PIN_OFF_BIT] = sleep_pin_function_off;
    end

    always_comb begin
        next_wake_word = 32'h00000000;
        next_wake_word[`UOHC_WK_HC_LSB +: CW] = next_hc_wake_cnt;
        next_wake_word[`UOHC_WK_DC_LSB +: CW] = next_dc_wake_cnt;
        next_wake_word[`UOHC_WK_IGN_LSB +: CW] = next_ignored_cnt;
    end

    always_comb begin
        unique case (uohc_decode(bus.rd_addr))
            UOHC_REG_CFG: bus.rd_data = next_cfg_word;
            UOHC_REG_STAT: bus.rd_data = status_word;
            UOHC_REG_WAKE: bus.rd_data = next_wake_word;
            UOHC_REG_NONE: bus.rd_data = 32'h00000000;
        endcase
    end
endmodule

// ==== uohc_consts.svh ====
// register map, field positions and reset values of the configuration block
// assumes inclusion by the package, the checker and the bench, one copy per compile
`ifndef UOHC_CONSTS_SVH
`define UOHC_CONSTS_SVH

// ==========================================================================
// register byte offsets (decode uses the low address bits)
`define UOHC_ADDR_W 12
`define UOHC_CFG_OFFSET 12'h000
`define UOHC_STAT_OFFSET 12'h004
`define UOHC_WAKE_OFFSET 12'h008

// ==========================================================================
// hardware_configuration fields
`define UOHC_SLEEP_OFF_BIT 15
`define UOHC_LOW_POWER_BIT 14
`define UOHC_PULLDOWN_BIT 13
`define UOHC_CFG_RESET 3'h0

// ==========================================================================
// status register fields
`define UOHC_ST_HC_PIN_BIT 0
`define UOHC_ST_DC_PIN_BIT 1
`define UOHC_ST_HC_SUSP_BIT 2
`define UOHC_ST_DC_SUSP_BIT 3
`define UOHC_ST_LOW_PWR_BIT 4
`define UOHC_ST_PULLDOWN_BIT 5
`define UOHC_ST_PIN_OFF_BIT 6

// ==========================================================================
// wake event counter register fields
`define UOHC_CNT_W 8
`define UOHC_WK_HC_LSB 0
`define UOHC_WK_DC_LSB 8
`define UOHC_WK_IGN_LSB 16
`define UOHC_CNT_RESET 8'h00

`endif

// ==== uohc_pkg.sv ====
// types and the register decode shared by the bus slave and the register bank
// assumes uohc_consts.svh sits in the same folder
package uohc_pkg;
`include "uohc_consts.svh"

    typedef logic [`UOHC_ADDR_W-1:0] uohc_addr_t;
    typedef logic [31:0] uohc_word_t;

    typedef enum logic [1:0] {
        UOHC_REG_CFG = 2'b00,
        UOHC_REG_STAT = 2'b01,
        UOHC_REG_WAKE = 2'b10,
        UOHC_REG_NONE = 2'b11
    } uohc_reg_e;

    typedef enum logic [1:0] {
        UOHC_PH_IDLE = 2'b00,
        UOHC_PH_WRITE = 2'b01,
        UOHC_PH_READ = 2'b10
    } uohc_phase_e;

    function automatic uohc_reg_e uohc_decode(input uohc_addr_t addr);
        uohc_reg_e sel;
        sel = UOHC_REG_NONE;
        if (addr == `UOHC_CFG_OFFSET) begin
            sel = UOHC_REG_CFG;
        end else if (addr == `UOHC_STAT_OFFSET) begin
            sel = UOHC_REG_STAT;
        end else if (addr == `UOHC_WAKE_OFFSET) begin
            sel = UOHC_REG_WAKE;
        end
        return sel;
    endfunction
endpackage

// ==== uohc_reg_if.sv ====
// register access path between the bus slave and the register bank
// assumes one slave and one bank on the same clock
`timescale 1ns/1ps
interface uohc_reg_if;
    import uohc_pkg::*;
    logic wr_en;
    uohc_addr_t wr_addr;
    uohc_word_t wr_data;
    uohc_addr_t rd_addr;
    uohc_word_t rd_data;

    modport slave (output wr_en, output wr_addr, output wr_data, output rd_addr,
        input rd_data);
    modport bank (input wr_en, input wr_addr, input wr_data, input rd_addr,
        output rd_data);
endinterface

// ==== uohc_ahb_slave.sv ====
// ahb-lite slave: zero wait states, always okay, registered read data
// assumes it is the only slave, so its hreadyout is the bus hready
`timescale 1ns/1ps
module uohc_ahb_slave
    import uohc_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic hready_in,
    input wire logic [31:0] hwdata_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    uohc_reg_if.slave bus
);
    uohc_phase_e phase;
    uohc_addr_t addr_q;
    logic accept;

    // ======================================================================
    // address phase
    assign accept = hsel_in & htrans_in[1] & hready_in;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            phase <= UOHC_PH_IDLE;
        end else if (accept) begin
            phase <= hwrite_in ? UOHC_PH_WRITE : UOHC_PH_READ;
        end else begin
            phase <= UOHC_PH_IDLE;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            addr_q <= '0;
        end else if (accept) begin
            addr_q <= haddr_in[`UOHC_ADDR_W-1:0];
        end
    end

    // ======================================================================
    // data phase; a write commits at the end of its data phase
    assign bus.wr_en = (phase == UOHC_PH_WRITE);
    assign bus.wr_addr = addr_q;
    assign bus.wr_data = hwdata_in;
    assign bus.rd_addr = haddr_in[`UOHC_ADDR_W-1:0];

    // read data is sampled at the address edge, cfg and wake words from the bank's next values,
    // so a read right behind a write already sees the written value
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            hrdata_out <= 32'h00000000;
        end else if (accept && !hwrite_in) begin
            hrdata_out <= bus.rd_data;
        end else begin
            hrdata_out <= 32'h00000000;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
        end else begin
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
        end
    end
endmodule

// ==== uohc_sleep_pin.sv ====
// one suspend/wakeup pin: drive, synchronise, detect wake requests
// assumes an external pull-up on the pin while it is released
`timescale 1ns/1ps
module uohc_sleep_pin (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic func_off_in,
    input wire logic suspend_in,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe_out,
    output logic level_out,
    output logic wake_out,
    output logic ignored_out
);
    logic sync1;
    logic sync2;
    logic level_prev;
    logic fall;

    // ======================================================================
    // pad drive
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pin_out <= 1'b1;
            pin_oe_out <= 1'b1;
        end else if (func_off_in) begin
            pin_out <= 1'b1;
            pin_oe_out <= 1'b1;
        end else begin
            // released in suspend so the far side can pull it low
            pin_out <= ~suspend_in;
            pin_oe_out <= ~suspend_in;
        end
    end

    // ======================================================================
    // input sampling
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sync1 <= 1'b1;
            sync2 <= 1'b1;
            level_prev <= 1'b1;
        end else begin
            sync1 <= pin_in;
            sync2 <= sync1;
            level_prev <= sync2;
        end
    end

    assign level_out = sync2;
    assign fall = level_prev & ~sync2;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wake_out <= 1'b0;
            ignored_out <= 1'b0;
        end else begin
            wake_out <= fall & suspend_in & ~func_off_in;
            ignored_out <= fall & func_off_in;
        end
    end
endmodule

// ==== uohc_top_chk.sv ====
// concurrent checks on the ports of the upper configuration bits block
// assumes one ahb-lite master and sleep pin levels fed back from the pads
`timescale 1ns/1ps
`include "uohc_consts.svh"
module uohc_top_chk (
    input wire logic SYS_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic HREADY_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic [31:0] HRDATA_OUT,
    input wire logic HC_SLEEP_PIN_IN,
    input wire logic HC_SLEEP_PIN_OUT,
    input wire logic HC_SLEEP_PIN_OE_OUT,
    input wire logic DC_SLEEP_PIN_OUT,
    input wire logic DC_SLEEP_PIN_OE_OUT,
    input wire logic HC_WAKE_OUT,
    input wire logic DC_WAKE_OUT,
    input wire logic TRX_SUSPEND_IN,
    input wire logic TRX_LOW_POWER_OUT,
    input wire logic PORT2_MINUS_PULLDOWN_OUT,
    input wire logic PORT2_PLUS_PULLDOWN_OUT
);
    // ==========================================================================
    // shadow of bits 15..13 rebuilt from bus traffic, so pad outputs can be judged
    logic [2:0] cfg_bits;
    logic wr_pend;
    logic rd_cfg;
    logic take;
    logic at_cfg;
    assign take = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
    assign at_cfg = (HADDR_IN[11:0] == `UOHC_CFG_OFFSET);
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            wr_pend <= 1'h0;
            rd_cfg <= 1'h0;
        end else begin
            wr_pend <= take && HWRITE_IN && at_cfg;
            rd_cfg <= take && !HWRITE_IN && at_cfg;
        end
    end
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_N_IN) begin
            cfg_bits <= 3'h0;
        end else if (wr_pend && HREADY_IN) begin
            cfg_bits <= HWDATA_IN[15:13];
        end
    end
    // ==========================================================================
    // assertions
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);
    // the pin is first sampled low one edge after it falls, the wake shows three edges later
    wake_delay_a: assert property (
        HC_WAKE_OUT |-> $past(HC_SLEEP_PIN_IN, 4) && !$past(HC_SLEEP_PIN_IN, 3))
        else $error("host wake not four edges after a pin fall");
    wake_pulse_a: assert property ($rose(DC_WAKE_OUT) |=> !DC_WAKE_OUT)
        else $error("peripheral wake longer than one cycle");
    hc_pin_high_a: assert property (
        $past(cfg_bits[2]) |-> HC_SLEEP_PIN_OUT && HC_SLEEP_PIN_OE_OUT)
        else $error("host sleep pin not held high while disabled");
    dc_pin_high_a: assert property (
        $past(cfg_bits[2]) |-> DC_SLEEP_PIN_OUT && DC_SLEEP_PIN_OE_OUT)
        else $error("peripheral sleep pin not held high while disabled");
    // the wake register is loaded with the disable bit as it stood one edge earlier
    no_wake_off_a: assert property (
        $past(cfg_bits[2]) |-> !HC_WAKE_OUT && !DC_WAKE_OUT)
        else $error("wake request while the pin function is off");
    low_power_a: assert property (
        TRX_LOW_POWER_OUT == ($past(cfg_bits[1]) && $past(TRX_SUSPEND_IN)))
        else $error("transceiver low power disagrees with bit 14 and suspend");
    pulldown_set_a: assert property (PORT2_MINUS_PULLDOWN_OUT == $past(cfg_bits[0]))
        else $error("port 2 pull-down disagrees with bit 13");
    pulldown_pair_a: assert property (PORT2_PLUS_PULLDOWN_OUT == PORT2_MINUS_PULLDOWN_OUT)
        else $error("port 2 pull-downs differ");
    cfg_readback_a: assert property (rd_cfg |-> HRDATA_OUT == {16'h0, cfg_bits, 13'h0})
        else $error("configuration read data wrong");
endmodule

bind uohc_top uohc_top_chk u_chk (
    .SYS_CLK_IN(SYS_CLK_IN),
    .RST_N_IN(RST_N_IN),
    .HSEL_IN(HSEL_IN),
    .HADDR_IN(HADDR_IN),
    .HTRANS_IN(HTRANS_IN),
    .HWRITE_IN(HWRITE_IN),
    .HREADY_IN(HREADY_IN),
    .HWDATA_IN(HWDATA_IN),
    .HRDATA_OUT(HRDATA_OUT),
    .HC_SLEEP_PIN_IN(HC_SLEEP_PIN_IN),
    .HC_SLEEP_PIN_OUT(HC_SLEEP_PIN_OUT),
    .HC_SLEEP_PIN_OE_OUT(HC_SLEEP_PIN_OE_OUT),
    .DC_SLEEP_PIN_OUT(DC_SLEEP_PIN_OUT),
    .DC_SLEEP_PIN_OE_OUT(DC_SLEEP_PIN_OE_OUT),
    .HC_WAKE_OUT(HC_WAKE_OUT),
    .DC_WAKE_OUT(DC_WAKE_OUT),
    .TRX_SUSPEND_IN(TRX_SUSPEND_IN),
    .TRX_LOW_POWER_OUT(TRX_LOW_POWER_OUT),
    .PORT2_MINUS_PULLDOWN_OUT(PORT2_MINUS_PULLDOWN_OUT),
    .PORT2_PLUS_PULLDOWN_OUT(PORT2_PLUS_PULLDOWN_OUT)
);

// ==== usb_otg_hw_config_upper_bits_test.sv ====
// self-checking bench for the upper configuration bits block
// assumes the bench is the only ahb-lite master and models both sleep pads
`timescale 1ns/1ps
`include "uohc_consts.svh"
module usb_otg_hw_config_upper_bits_test;
    import uohc_pkg::*;
    // ==========================================================================
    // stimulus and observation
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [31:0] hwdata = 32'h0;
    logic hc_susp = 1'h0, dc_susp = 1'h0, trx_susp = 1'h0;
    logic hc_low = 1'h0, dc_low = 1'h0, rd_flag = 1'h0;
    wire [31:0] hrdata;
    wire hready, hresp, hc_out, hc_oe, dc_out, dc_oe, hc_wake, dc_wake, low_pwr, pd_m, pd_p;
    wire hc_pin, dc_pin;
    int fail_count = 0;
    int num_checks = 0;
    int seed = 50824;
    int hc_wakes = 0;
    int dc_wakes = 0;
    uohc_word_t exp_q[$];
    always #2.5 clk = ~clk;
    // a bench pull-low beats the pad driver; a released pad floats up on its pull-up
    assign hc_pin = hc_low ? 1'h0 : (hc_oe ? hc_out : 1'h1);
    assign dc_pin = dc_low ? 1'h0 : (dc_oe ? dc_out : 1'h1);
    uohc_top DUT (
        .SYS_CLK_IN(clk), .RST_N_IN(rst_n), .HSEL_IN(hsel), .HADDR_IN(haddr),
        .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HREADY_IN(hready),
        .HWDATA_IN(hwdata), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
        .HC_SUSPEND_IN(hc_susp), .DC_SUSPEND_IN(dc_susp), .TRX_SUSPEND_IN(trx_susp),
        .HC_SLEEP_PIN_IN(hc_pin), .HC_SLEEP_PIN_OUT(hc_out), .HC_SLEEP_PIN_OE_OUT(hc_oe),
        .DC_SLEEP_PIN_IN(dc_pin), .DC_SLEEP_PIN_OUT(dc_out), .DC_SLEEP_PIN_OE_OUT(dc_oe),
        .HC_WAKE_OUT(hc_wake), .DC_WAKE_OUT(dc_wake), .TRX_LOW_POWER_OUT(low_pwr),
        .PORT2_MINUS_PULLDOWN_OUT(pd_m), .PORT2_PLUS_PULLDOWN_OUT(pd_p)
    );
    // ==========================================================================
    // shared tasks
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (fail_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic bus_addr(input uohc_addr_t a, input logic wr);
        hsel <= 1'h1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
    endtask
    task automatic ahb_write(input uohc_addr_t a, input uohc_word_t d);
        bus_addr(a, 1'h1);
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'h1);
    endtask
    // the expectation is queued here and judged by the monitor below
    task automatic ahb_read(input uohc_addr_t a, input uohc_word_t e);
        exp_q.push_back(e);
        bus_addr(a, 1'h0);
        rd_flag <= 1'h1;
        hwdata <= $random(seed);
        do @(posedge clk); while (hready !== 1'h1);
        rd_flag <= 1'h0;
    endtask
    task automatic pulse_low(input logic on_dc);
        if (on_dc) begin
            dc_low <= 1'h1;
        end else begin
            hc_low <= 1'h1;
        end
        repeat (8) @(posedge clk);
        dc_low <= 1'h0;
        hc_low <= 1'h0;
        repeat (8) @(posedge clk);
    endtask
    always @(posedge clk) begin
        if (rd_flag) begin
            check("hrdata", hrdata, exp_q.pop_front());
            check("hresp", {31'h0, hresp}, 32'h0);
        end
        if (hc_wake === 1'h1) begin
            hc_wakes++;
        end
        if (dc_wake === 1'h1) begin
            dc_wakes++;
        end
    end
    // ==========================================================================
    // scenarios
    initial begin
        uohc_word_t d;
        int i;
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        ahb_read(`UOHC_CFG_OFFSET, 32'h0);
        ahb_read(`UOHC_WAKE_OFFSET, 32'h0);
        // every bit combination, neighbouring bits random, an unmapped word between
        for (i = 0; i < 8; i++) begin
            d = $random(seed);
            trx_susp <= d[0];
            // a suspended controller releases its pin unless the function is off
            hc_susp <= d[1];
            dc_susp <= d[2];
            ahb_write(`UOHC_CFG_OFFSET, {d[31:16], i[2:0], d[12:0]});
            ahb_write(12'h00C, d);
            ahb_read(`UOHC_CFG_OFFSET, {16'h0, i[2:0], 13'h0});
            ahb_read(12'h00C, 32'h0);
            repeat (2) @(posedge clk);
            #1;
            check("pulldown", {31'h0, pd_m}, {31'h0, i[0]});
            check("pulldown_pair", {31'h0, pd_p}, {31'h0, i[0]});
            check("low_power", {31'h0, low_pwr}, {31'h0, i[1] & d[0]});
            check("pins", {28'h0, hc_out, hc_oe, dc_out, dc_oe},
                {28'h0, {2{i[2] | ~d[1]}}, {2{i[2] | ~d[2]}}});
            @(posedge clk);
        end
        // function on, both suspended: one wake per pin
        ahb_write(`UOHC_CFG_OFFSET, 32'h0);
        ahb_write(`UOHC_WAKE_OFFSET, 32'h0);
        hc_susp <= 1'h1;
        dc_susp <= 1'h1;
        repeat (4) @(posedge clk);
        pulse_low(1'h0);
        pulse_low(1'h1);
        check("hc_wakes", hc_wakes, 1);
        check("dc_wakes", dc_wakes, 1);
        ahb_read(`UOHC_WAKE_OFFSET, 32'h0000_0101);
        // function off: pins high, lows ignored
        ahb_write(`UOHC_CFG_OFFSET, 32'h8000);
        ahb_write(`UOHC_WAKE_OFFSET, 32'h0);
        repeat (4) @(posedge clk);
        ahb_read(`UOHC_STAT_OFFSET, 32'h0000_004F);
        pulse_low(1'h0);
        pulse_low(1'h1);
        check("wakes_off", hc_wakes + dc_wakes, 2);
        ahb_read(`UOHC_WAKE_OFFSET, 32'h0002_0000);
        give_verdict();
    end
    // the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        give_verdict();
    end
endmodule
